// >>> rtl/psr_defs.svh
// Register offsets, field positions and reset values of the peripheral soft reset controller
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH

`define PSR_ADDR_W          16
`define PSR_DATA_W          16
`define PSR_OFS_CYCLE_COUNT 16'h1c04
`define PSR_OFS_GROUP_CTRL  16'h1c05

`define PSR_CYCLE_COUNT_RST 16'h0000
`define PSR_GROUP_CTRL_RST  16'h0000
`define PSR_COUNT_INIT_HINT 16'h0020
`define PSR_GROUP_CTRL_MASK 16'h00bb

`define PSR_BIT_I2C         0
`define PSR_BIT_EXTMEM_TMR  1
`define PSR_BIT_USB         3
`define PSR_BIT_DMA         4
`define PSR_BIT_CARD_AUDIO  5
`define PSR_BIT_AUDIO23_SER 7

`define PSR_ZERO_WORD       16'h0000
`define PSR_ONE_WORD        16'h0001

`define PSR_RESET_RELEASED  1'b1

`endif

// >>> rtl/psr_pkg.sv
// Types shared by the peripheral soft reset controller
package psr_pkg;
    typedef logic [15:0] psr_word_type;
    typedef logic [15:0] psr_addr_type;
endpackage : psr_pkg

// >>> rtl/psr_peripheral_soft_reset_ctrl.sv
// Peripheral soft reset controller: count register, group reset bits, reset outputs
// Behaviour
// R1: 16-bit writable cycle count field
// R2: Counter at zero clears all reset bits
// R3: Software loads count 20h beforehand
// R4: Software programs count, then sets bits
// R5: Set bit drives group reset low
// R6: Bit 7 resets audio 2/3, UART, SPI
// R7: Bit 5 resets card 0, audio 0/1
// R8: Bit 4 resets all DMA controllers
// R9: Bit 3 resets USB controller
// R10: Bit 1 resets external memory, timers
// R11: Bit 0 resets I2C controller
// R12: One means in reset, zero released
// R13: Reserved bits read zero, written zero
// R14: Set bits load counter; restart on reset
`timescale 1ns/1ps
`include "psr_defs.svh"

module psr_peripheral_soft_reset_ctrl (
    input  wire logic                 core_clk,               // System clock, 40 MHz
    input  wire logic                 reset_n,                // Async power-on reset
    input  wire psr_pkg::psr_addr_type regAddr,               // Register address
    input  wire psr_pkg::psr_word_type regWriteData,          // Write data
    input  wire logic                 regWrite,               // Write strobe
    input  wire logic                 regRead,                // Read strobe
    output psr_pkg::psr_word_type     regReadData,            // Read data, cycle after strobe
    output logic                      audio23SerialGroupResetN, // Audio 2/3, UART, SPI reset
    output logic                      cardAudio01GroupResetN, // Card 0, audio 0/1 reset
    output logic                      dmaGroupResetN,         // All DMA controllers reset
    output logic                      usbGroupResetN,         // USB controller reset
    output logic                      extmemTimerGroupResetN, // External memory, timers reset
    output logic                      i2cGroupResetN          // I2C controller reset
);
    import psr_pkg::*;

    // Idle while no group bit is held, counting while any one is
    typedef enum logic {
        PSR_IDLE,
        PSR_COUNTING
    } psr_state_type;

    // Exact match of the word address against one register offset
    function automatic logic addr_hit(
        input psr_addr_type addr,
        input psr_addr_type offset
    );
        return (addr == offset);
    endfunction : addr_hit

    // Keeps only the writable group bits of a control word
    function automatic psr_word_type writable_bits(
        input psr_word_type word
    );
        return word & `PSR_GROUP_CTRL_MASK;
    endfunction : writable_bits

    // True when any bit of a word is set
    function automatic logic any_set(
        input psr_word_type word
    );
        return (word != `PSR_ZERO_WORD);
    endfunction : any_set

    // Active-low line level for one group bit of a control word
    function automatic logic line_level(
        input psr_word_type ctrl,
        input int           bitPos
    );
        return ~ctrl[bitPos];
    endfunction : line_level

    // Register read selection; unmapped offsets return zero
    function automatic psr_word_type read_select(
        input logic         hitCount,
        input logic         hitCtrl,
        input psr_word_type countWord,
        input psr_word_type ctrlWord
    );
        psr_word_type word;
        word = `PSR_ZERO_WORD;
        if (hitCount) begin
            word = countWord;
        end else if (hitCtrl) begin
            word = ctrlWord;
        end
        return word;
    endfunction : read_select

    psr_state_type state_reg;
    psr_state_type state_next;
    psr_word_type  cycleCount_reg;
    psr_word_type  cycleCount_next;
    psr_word_type  groupCtrl_reg;
    psr_word_type  groupCtrl_next;
    psr_word_type  counter_reg;
    psr_word_type  counter_next;
    psr_word_type  readData_next;

    wire logic         selCount;
    wire logic         selCtrl;
    wire logic         wrCount;
    wire logic         wrCtrl;
    wire psr_word_type wrCtrlBits;
    wire logic         startReset;
    wire logic         active;
    wire logic         expire;
    wire psr_word_type counterDown;

    wire logic         audio23Level_next;
    wire logic         cardAudio01Level_next;
    wire logic         dmaLevel_next;
    wire logic         usbLevel_next;
    wire logic         extmemTimerLevel_next;
    wire logic         i2cLevel_next;

    // Address decode
    assign selCount    = addr_hit(regAddr, `PSR_OFS_CYCLE_COUNT);
    assign selCtrl     = addr_hit(regAddr, `PSR_OFS_GROUP_CTRL);
    assign wrCount     = regWrite && selCount;
    assign wrCtrl      = regWrite && selCtrl;

    // Reserved bits are never stored, so they always read back zero
    assign wrCtrlBits  = writable_bits(regWriteData);                     // [R13]
    assign startReset  = wrCtrl && any_set(wrCtrlBits);                   // [R14]
    assign active      = (state_reg == PSR_COUNTING);

    // Counter expires after the last asserted cycle; a count of zero still gives one cycle
    assign expire      = active && (counter_reg <= `PSR_ONE_WORD);       // [R2]
    assign counterDown = counter_reg - `PSR_ONE_WORD;

    assign cycleCount_next = wrCount ? regWriteData : cycleCount_reg;     // [R1]

    // A write replaces the group bits; writing zero releases them early
    assign groupCtrl_next = wrCtrl ? wrCtrlBits :                         // [R12]
                            expire ? `PSR_ZERO_WORD : groupCtrl_reg;      // [R2]

    // Reload on every write that sets a bit, even mid-count
    assign counter_next = startReset ? cycleCount_reg :                   // [R14]
                          expire     ? `PSR_ZERO_WORD :
                          active     ? counterDown : counter_reg;

    // Read data is zero outside the cycle after a read strobe
    assign readData_next = regRead ? read_select(selCount, selCtrl,
                                                 cycleCount_reg,
                                                 groupCtrl_reg)
                                   : `PSR_ZERO_WORD;                      // [R13]

    // Line levels follow the next control word so each pin flop tracks its bit
    assign audio23Level_next     = line_level(groupCtrl_next, `PSR_BIT_AUDIO23_SER);
    assign cardAudio01Level_next = line_level(groupCtrl_next, `PSR_BIT_CARD_AUDIO);
    assign dmaLevel_next         = line_level(groupCtrl_next, `PSR_BIT_DMA);
    assign usbLevel_next         = line_level(groupCtrl_next, `PSR_BIT_USB);
    assign extmemTimerLevel_next = line_level(groupCtrl_next, `PSR_BIT_EXTMEM_TMR);
    assign i2cLevel_next         = line_level(groupCtrl_next, `PSR_BIT_I2C);

    // Sequencer: tracks whether any group is held in reset
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PSR_IDLE: begin
                if (startReset) begin
                    state_next = PSR_COUNTING;
                end
            end
            PSR_COUNTING: begin
                if (startReset) begin
                    state_next = PSR_COUNTING;
                end else if (wrCtrl) begin
                    // A write with no writable bit set releases at once
                    state_next = PSR_IDLE;
                end else if (expire) begin
                    state_next = PSR_IDLE;                                // [R2]
                end
            end
            default: begin
                state_next = PSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= PSR_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cycleCount_reg <= `PSR_CYCLE_COUNT_RST;
        end else begin
            cycleCount_reg <= cycleCount_next;                            // [R1]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            groupCtrl_reg <= `PSR_GROUP_CTRL_RST;
        end else begin
            groupCtrl_reg <= groupCtrl_next;                              // [R12]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            counter_reg <= `PSR_ZERO_WORD;
        end else begin
            counter_reg <= counter_next;                                  // [R14]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            regReadData <= `PSR_ZERO_WORD;
        end else begin
            regReadData <= readData_next;
        end
    end

    // Each reset line is its own flop, so no decode glitch reaches a peripheral
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            audio23SerialGroupResetN <= `PSR_RESET_RELEASED;
        end else begin
            audio23SerialGroupResetN <= audio23Level_next;                // [R6] [R5]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cardAudio01GroupResetN <= `PSR_RESET_RELEASED;
        end else begin
            cardAudio01GroupResetN <= cardAudio01Level_next;              // [R7] [R5]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            dmaGroupResetN <= `PSR_RESET_RELEASED;
        end else begin
            dmaGroupResetN <= dmaLevel_next;                              // [R8] [R5]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            usbGroupResetN <= `PSR_RESET_RELEASED;
        end else begin
            usbGroupResetN <= usbLevel_next;                              // [R9] [R5]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            extmemTimerGroupResetN <= `PSR_RESET_RELEASED;
        end else begin
            extmemTimerGroupResetN <= extmemTimerLevel_next;              // [R10] [R5]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            i2cGroupResetN <= `PSR_RESET_RELEASED;
        end else begin
            i2cGroupResetN <= i2cLevel_next;                              // [R11] [R5]
        end
    end

endmodule : psr_peripheral_soft_reset_ctrl

// >>> tb/psr_periph_model.sv
// Peripheral group model: logs the length of each reset pulse
`timescale 1ns/1ps
module psr_periph_model (input wire logic core_clk, rstN, output int lowLen);
    int run = 0;
    always @(posedge core_clk)
        if (!rstN) run <= run + 1; // Held in reset while low
        else if (run != 0) begin lowLen <= run; run <= 0; end
endmodule : psr_periph_model

// >>> tb/psr_properties.sv
// Port assertions for the soft reset controller
`timescale 1ns/1ps
module psr_checker (input wire logic core_clk, reset_n, regWrite, regRead, i2cGroupResetN,
    input wire logic audio23SerialGroupResetN, input wire logic [15:0] regAddr, regWriteData,
    input wire logic [15:0] regReadData);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire i2c = i2cGroupResetN, aud = audio23SerialGroupResetN;
    wire wrC = regWrite && regAddr == 16'h1c05, rdC = regRead && regAddr == 16'h1c05;
    sequence s_cw; regWrite && regAddr == 16'h1c04 ##1 !regWrite; endsequence
    sequence s_cr; regRead && regAddr == 16'h1c04; endsequence
    property p_cnt; s_cw ##1 s_cr |=> regReadData == $past(regWriteData, 3); endproperty
    property p_wr0; wrC |=> i2c != $past(regWriteData[0]); endproperty
    property p_wr7; wrC |=> aud != $past(regWriteData[7]); endproperty
    property p_rd0; rdC |=> regReadData[0] != $past(i2c); endproperty
    property p_rd7; rdC |=> regReadData[7] != $past(aud); endproperty
    property p_rsv; rdC |=> !(regReadData & 16'hff44); endproperty
    // A reset may only start from a control write, never on its own
    property p_on0; $fell(i2c) |-> $past(wrC); endproperty
    property p_on7; $fell(aud) |-> $past(wrC); endproperty
    a_cnt: assert property (p_cnt) else $error("count");
    a_wr0: assert property (p_wr0) else $error("wr0");
    a_wr7: assert property (p_wr7) else $error("wr7");
    a_rd0: assert property (p_rd0) else $error("rd0");
    a_rd7: assert property (p_rd7) else $error("rd7");
    a_rsv: assert property (p_rsv) else $error("rsv");
    a_on0: assert property (p_on0) else $error("on0");
    a_on7: assert property (p_on7) else $error("on7");
endmodule : psr_checker
bind psr_peripheral_soft_reset_ctrl psr_checker chk (.*);

// >>> tb/tb_top.sv
// Bench for the soft reset controller
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 0, reset_n = 0, regWrite = 0, regRead = 0;
    logic [15:0] regAddr = 0, regWriteData = 0, regReadData, d;
    logic [5:0] rN;
    int num_errors = 0, tests_run = 0, lowLen, bits[6] = '{0, 1, 3, 4, 5, 7};
    always #12.5 core_clk = ~core_clk;
    psr_peripheral_soft_reset_ctrl uut (.*, .audio23SerialGroupResetN(rN[5]),
        .cardAudio01GroupResetN(rN[4]), .dmaGroupResetN(rN[3]), .usbGroupResetN(rN[2]),
        .extmemTimerGroupResetN(rN[1]), .i2cGroupResetN(rN[0]));
    psr_periph_model peer (.core_clk, .rstN(rN[0]), .lowLen);
    task automatic cmp(logic [15:0] got, exp);
        tests_run++;
        if (got !== exp) begin num_errors++; $display("[FAIL] %0t %h %h", $time, got, exp); end
    endtask : cmp
    task automatic acc(logic w, logic [15:0] a, v = 0);
        @(posedge core_clk) {regWrite, regRead, regAddr, regWriteData} <= {w, !w, a, v};
        @(posedge core_clk) {regWrite, regRead} <= 2'b00;
        #1 d = regReadData;
    endtask : acc
    task automatic print_verdict;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20) @(posedge core_clk);
        reset_n <= 1;
        acc(0, 16'h1c05); cmp(d, 16'h0000);
        acc(1, 16'h1c04, 16'h0020); acc(0, 16'h1c04); cmp(d, 16'h0020);
        foreach (bits[i]) begin
            acc(1, 16'h1c05, 16'h0001 << bits[i]);
            cmp(rN ^ 6'h3f, 16'h0001 << i);
        end
        acc(1, 16'h1c05, 16'hffff); acc(0, 16'h1c05); cmp(d, 16'h00bb);
        repeat (40) @(posedge core_clk);
        cmp(lowLen, 16'h0020); cmp(rN, 16'h003f);
        // Second write two cycles in restarts the full interval
        acc(1, 16'h1c05, 16'h0001); acc(1, 16'h1c05, 16'h0001);
        repeat (40) @(posedge core_clk);
        cmp(lowLen, 16'h0022);
        acc(1, 16'h1c06, 16'hffff); acc(0, 16'h1c06); cmp(d, 16'h0000);
        print_verdict();
    end
    initial begin #50us; num_errors++; print_verdict(); end
endmodule : tb_top
